//--- common/alu_pkg.sv
// Purpose: Shared constants and types for the shift/arith/table-fetch datapath slice.
// Assumes: 8-bit data, 15-bit program counter, 16-bit pointers.
// Notes: Operation codes are local to this slice, not an instruction encoding.
package alu_pkg;
   localparam int data_w = 8;
   localparam int pc_w = 15;
   localparam int ptr_w = 16;
   localparam int prog_sel_bit = 15;
   localparam logic [7:0] status_rst = 8'h00;
   localparam logic [7:0] wreg_rst = 8'h00;
   localparam logic [6:0] latch_rst = 7'h00;
   localparam logic [15:0] ptr_rst = 16'h0000;
   localparam logic [14:0] pc_rst = 15'h0000;
   localparam int prog_read_cycles = 2;
   localparam int data_read_cycles = 1;
   localparam int call_by_accumulator_op_cycles = 2;
   localparam int return_with_literal_op_cycles = 2;
   localparam int brw_cycles = 2;
   localparam int table_lookup_cycles = call_by_accumulator_op_cycles + 2 + return_with_literal_op_cycles;

   typedef enum logic [3:0] {
      op_nop = 4'h0,
      add_with_carry_op = 4'h1,
      subtract_with_borrow_op = 4'h2,
      arith_shift_right_op = 4'h3,
      logic_shift_right_op = 4'h4,
      logic_shift_left_op = 4'h5,
      indirect_load_op = 4'h6,
      branch_by_accumulator_op = 4'h7,
      call_by_accumulator_op = 4'h8,
      return_with_literal_op = 4'h9
   } op_t;

   // The left alias shares the plain left shift encoding.
   localparam op_t arith_shift_left_alias = logic_shift_left_op;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_wait = 2'b01
   } state_t;
endpackage

//--- common/alu_if.sv
// Purpose: Carrier between the datapath top and its arithmetic unit.
// Assumes: Single clock domain, purely combinational unit.
// Notes: None.
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
   import alu_pkg::*;
   op_t op;
   logic [7:0] a;
   logic [7:0] b;
   logic c_in;
   logic [7:0] y;
   logic c_out;
   logic dc_out;
   logic z_out;
   modport top (output op, output a, output b, output c_in,
                input y, input c_out, input dc_out, input z_out);
   modport unit (input op, input a, input b, input c_in,
                 output y, output c_out, output dc_out, output z_out);
endinterface
`default_nettype wire

//--- verilog/alu_unit.sv
// Purpose: Combinational add/subtract/shift unit with carry, digit carry and zero.
// Assumes: Operand a is the file register, b is the working register.
// Notes: Carry follows the no-borrow convention for subtraction.
`timescale 1ns/1ps
`default_nettype none
module alu_unit
   import alu_pkg::*;
(
   alu_if.unit u
);
   logic [8:0] sum;
   logic [4:0] nib;
   always_comb begin
      sum = 9'h000;
      nib = 5'h00;
      u.y = u.a;
      u.c_out = u.c_in;
      u.dc_out = 1'b0;
      case (u.op)
         add_with_carry_op: begin
            sum = {1'b0, u.a} + {1'b0, u.b} + {8'h00, u.c_in};
            nib = {1'b0, u.a[3:0]} + {1'b0, u.b[3:0]} + {4'h0, u.c_in};
            u.y = sum[7:0];
            u.c_out = sum[8];
            u.dc_out = nib[4];
         end
         subtract_with_borrow_op: begin
            // Clear carry means a borrow is pending from the lower byte.
            sum = {1'b0, u.a} + {1'b0, ~u.b} + {8'h00, u.c_in};
            nib = {1'b0, u.a[3:0]} + {1'b0, ~u.b[3:0]} + {4'h0, u.c_in};
            u.y = sum[7:0];
            u.c_out = sum[8];
            u.dc_out = nib[4];
         end
         arith_shift_right_op: begin
            u.y = {u.a[7], u.a[7:1]};
            u.c_out = u.a[0];
         end
         logic_shift_right_op: begin
            u.y = {1'b0, u.a[7:1]};
            u.c_out = u.a[0];
         end
         logic_shift_left_op: begin
            u.y = {u.a[6:0], 1'b0};
            u.c_out = u.a[7];
         end
         default: begin
            u.y = u.a;
            u.c_out = u.c_in;
         end
      endcase
      u.z_out = (u.y == 8'h00);
   end
endmodule
`default_nettype wire

//--- verilog/alu_core.sv
// Purpose: Execution slice for carry arithmetic, shifts, table fetch and table calls.
// Assumes: Decode presents one operation with issue high; the core waits while busy.
// Notes: Stack is a single return slot handed in and out by the surrounding core.
`timescale 1ns/1ps
`default_nettype none
module alu_core
   import alu_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic issue,
   input wire op_t op,
   input wire logic [7:0] file_in,
   input wire logic [7:0] literal,
   input wire logic wreg_load,
   input wire logic [7:0] wreg_in,
   input wire logic latch_load,
   input wire logic [6:0] latch_in,
   input wire logic ptr_lo_load,
   input wire logic ptr_hi_load,
   input wire logic [7:0] ptr_byte_in,
   input wire logic [13:0] prog_word,
   input wire logic [7:0] ram_data,
   input wire logic [14:0] stack_top,
   output logic busy,
   output logic done,
   output logic [7:0] result,
   output logic [7:0] wreg,
   output logic carry,
   output logic digit_carry,
   output logic zero,
   output logic [14:0] pc,
   output logic [7:0] pointer0_low_byte,
   output logic [7:0] pointer0_high_byte,
   output logic [14:0] prog_addr,
   output logic [15:0] ram_addr,
   output logic push,
   output logic pop,
   output logic [14:0] push_addr
);
   typedef struct packed {
      state_t st;
      op_t op;
      logic [7:0] wreg;
      logic c;
      logic dc;
      logic z;
      logic [6:0] latch;
      logic [15:0] ptr;
      logic [14:0] pc;
      logic [7:0] res;
      logic done;
      logic push;
      logic pop;
      logic [14:0] push_addr;
   } core_t;

   core_t q;
   core_t d;
   alu_if au();

   alu_unit i_alu_unit (
      .u(au.unit)
   );

   function automatic logic [14:0] pc_plus(input logic [14:0] p, input logic [7:0] off);
      pc_plus = p + {7'h00, off};
   endfunction

   assign au.op = op;
   assign au.a = file_in;
   assign au.b = q.wreg;
   assign au.c_in = q.c;

   always_comb begin
      d = q;
      d.done = 1'b0;
      d.push = 1'b0;
      d.pop = 1'b0;
      if (wreg_load) begin
         d.wreg = wreg_in;
      end
      if (latch_load) begin
         d.latch = latch_in;
      end
      if (ptr_lo_load) begin
         d.ptr[7:0] = ptr_byte_in;
      end
      if (ptr_hi_load) begin
         d.ptr[15:8] = ptr_byte_in;
      end
      case (q.st)
         st_idle: begin
            if (issue) begin
               d.op = op;
               d.pc = pc_plus(q.pc, 8'h01);
               case (op)
                  add_with_carry_op, subtract_with_borrow_op: begin
                     d.res = au.y;
                     d.c = au.c_out;
                     d.dc = au.dc_out;
                     d.z = au.z_out;
                     d.done = 1'b1;
                  end
                  arith_shift_right_op, logic_shift_right_op, logic_shift_left_op: begin
                     d.res = au.y;
                     d.c = au.c_out;
                     d.z = au.z_out;
                     d.done = 1'b1;
                  end
                  indirect_load_op: begin
                     if (q.ptr[prog_sel_bit]) begin
                        d.st = st_wait;
                     end else begin
                        d.wreg = ram_data;
                        d.z = (ram_data == 8'h00);
                        d.done = 1'b1;
                     end
                  end
                  branch_by_accumulator_op, call_by_accumulator_op,
                  return_with_literal_op: begin
                     d.st = st_wait;
                  end
                  default: begin
                     d.done = 1'b1;
                  end
               endcase
            end
         end
         st_wait: begin
            // Second cycle takes the program word for a table fetch, or sets pc for a change of flow, pushing for a call and popping for a return.
            d.st = st_idle;
            d.done = 1'b1;
            case (q.op)
               indirect_load_op: begin
                  d.wreg = prog_word[7:0];
                  d.z = (prog_word[7:0] == 8'h00);
               end
               branch_by_accumulator_op: begin
                  d.pc = pc_plus(q.pc, q.wreg);
               end
               call_by_accumulator_op: begin
                  d.push = 1'b1;
                  d.push_addr = q.pc;
                  d.pc = {q.latch, q.wreg};
               end
               return_with_literal_op: begin
                  d.wreg = literal;
                  d.pop = 1'b1;
                  d.pc = stack_top;
               end
               default: begin
                  d.pc = q.pc;
               end
            endcase
         end
         default: begin
            d.st = st_idle;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{st: st_idle, op: op_nop, wreg: wreg_rst, c: 1'b0, dc: 1'b0, z: 1'b0,
                latch: latch_rst, ptr: ptr_rst, pc: pc_rst, res: 8'h00, done: 1'b0,
                push: 1'b0, pop: 1'b0, push_addr: pc_rst};
      end else begin
         q <= d;
      end
   end

   assign busy = (q.st != st_idle);
   assign done = q.done;
   assign result = q.res;
   assign wreg = q.wreg;
   assign carry = q.c;
   assign digit_carry = q.dc;
   assign zero = q.z;
   assign pc = q.pc;
   assign pointer0_low_byte = q.ptr[7:0];
   assign pointer0_high_byte = q.ptr[15:8];
   // Program space is word addressed, so the selector bit is dropped.
   assign prog_addr = q.ptr[14:0];
   assign ram_addr = q.ptr;
   assign push = q.push;
   assign pop = q.pop;
   assign push_addr = q.push_addr;

   // Checks.
   sequence s_issue_prog;
      issue && !busy && op == indirect_load_op && q.ptr[prog_sel_bit];
   endsequence

   property p_prog_two;
      @(posedge clock) disable iff (!rst_n)
      s_issue_prog |=> busy ##1 (done && !busy);
   endproperty
   a_prog_two: assert property (p_prog_two) else $error("program fetch not two cycles");

   property p_prog_data;
      @(posedge clock) disable iff (!rst_n)
      s_issue_prog ##1 1'b1 |=> wreg == $past(prog_word[7:0]);
   endproperty
   a_prog_data: assert property (p_prog_data) else $error("program fetch data wrong");

   property p_ram_one;
      @(posedge clock) disable iff (!rst_n)
      issue && !busy && op == indirect_load_op && !q.ptr[prog_sel_bit] && !wreg_load
      |=> done && !busy && wreg == $past(ram_data);
   endproperty
   a_ram_one: assert property (p_ram_one) else $error("ram fetch wrong");

   property p_asr;
      @(posedge clock) disable iff (!rst_n)
      issue && !busy && op == arith_shift_right_op
      |=> result == {$past(file_in[7]), $past(file_in[7:1])} && carry == $past(file_in[0]);
   endproperty
   a_asr: assert property (p_asr) else $error("arith right shift wrong");

   property p_lsr;
      @(posedge clock) disable iff (!rst_n)
      issue && !busy && op == logic_shift_right_op
      |=> result == {1'b0, $past(file_in[7:1])} && carry == $past(file_in[0]);
   endproperty
   a_lsr: assert property (p_lsr) else $error("logic right shift wrong");

   property p_lsl;
      @(posedge clock) disable iff (!rst_n)
      issue && !busy && op == logic_shift_left_op
      |=> result == {$past(file_in[6:0]), 1'b0} && carry == $past(file_in[7]);
   endproperty
   a_lsl: assert property (p_lsl) else $error("left shift wrong");

   property p_adc;
      @(posedge clock) disable iff (!rst_n)
      issue && !busy && op == add_with_carry_op
      |=> {carry, result} == {1'b0, $past(file_in)} + {1'b0, $past(q.wreg)} + {8'h00, $past(q.c)};
   endproperty
   a_adc: assert property (p_adc) else $error("add with carry wrong");

   property p_call_by_accumulator_op;
      @(posedge clock) disable iff (!rst_n)
      issue && !busy && op == call_by_accumulator_op && !wreg_load && !latch_load
      |=> ##1 push && pc == {$past(q.latch, 2), $past(q.wreg, 2)};
   endproperty
   a_call_by_accumulator_op: assert property (p_call_by_accumulator_op) else $error("call target wrong");

   property p_return_with_literal_op;
      @(posedge clock) disable iff (!rst_n)
      issue && !busy && op == return_with_literal_op
      |=> ##1 pop && pc == $past(stack_top) && wreg == $past(literal);
   endproperty
   a_return_with_literal_op: assert property (p_return_with_literal_op) else $error("return with literal wrong");

   sequence s_issue_branch;
      issue && !busy && op == branch_by_accumulator_op;
   endsequence

   property p_brw;
      @(posedge clock) disable iff (!rst_n)
      s_issue_branch |=> busy ##1 (done && pc == $past(pc) + {7'h00, $past(wreg)});
   endproperty
   a_brw: assert property (p_brw) else $error("branch by working register wrong");

   property p_sbb;
      @(posedge clock) disable iff (!rst_n)
      issue && !busy && op == subtract_with_borrow_op
      |=> result == $past(file_in) - $past(q.wreg) - {7'h00, !$past(q.c)}
          && carry == ({1'b0, $past(file_in)} >= {1'b0, $past(q.wreg)} + {8'h00, !$past(q.c)});
   endproperty
   a_sbb: assert property (p_sbb) else $error("subtract with borrow wrong");

   property p_adc_flags;
      @(posedge clock) disable iff (!rst_n)
      issue && !busy && op == add_with_carry_op
      |=> zero == (result == 8'h00)
          && digit_carry == ($past(file_in[3:0]) + $past(q.wreg[3:0]) + $past(q.c) > 5'h0f);
   endproperty
   a_adc_flags: assert property (p_adc_flags) else $error("add with carry flags wrong");

   property p_ptr_hi;
      @(posedge clock) disable iff (!rst_n)
      ptr_hi_load
      |=> pointer0_high_byte == $past(ptr_byte_in) && prog_addr[14:8] == $past(ptr_byte_in[6:0]);
   endproperty
   a_ptr_hi: assert property (p_ptr_hi) else $error("pointer high byte load wrong");

   property p_call_ret;
      @(posedge clock) disable iff (!rst_n)
      issue && !busy && op == call_by_accumulator_op
      |=> ##1 push_addr == $past(pc) && !busy;
   endproperty
   a_call_ret: assert property (p_call_ret) else $error("call return address wrong");
endmodule
`default_nettype wire

//--- bench/alu_shift_and_table_fetch_tb.sv
// Purpose: Self-checking bench for the carry arithmetic, shift and table fetch slice.
// Assumes: Registered outputs are sampled at the edge after the one that sets them.
// Notes: The driver queues each expectation; a monitor checks it when done pulses.
`timescale 1ns/1ps
`default_nettype none
module alu_shift_and_table_fetch_tb;
   import alu_pkg::*;
   typedef struct {
      int kind;
      logic [7:0] res;
      logic c, dc, z;
      logic [7:0] w;
      logic [14:0] pc, paddr;
      logic pu, po;
   } note_t;
   logic clock = 1'b0, rst_n = 1'b0, issue = 1'b0;
   op_t op = op_nop;
   logic [7:0] file_in = 8'h00, literal = 8'h00, wreg_in = 8'h00, ptr_byte_in = 8'h00;
   logic [7:0] ram_data = 8'h00;
   logic wreg_load = 1'b0, latch_load = 1'b0, ptr_lo_load = 1'b0, ptr_hi_load = 1'b0;
   logic [6:0] latch_in = 7'h00;
   logic [13:0] prog_word = 14'h0000;
   logic [14:0] stack_top = 15'h0000;
   logic busy, done, carry, digit_carry, zero, push, pop;
   logic [7:0] result, wreg, pointer0_low_byte, pointer0_high_byte;
   logic [14:0] pc, prog_addr, push_addr;
   logic [15:0] ram_addr;
   note_t q[$];
   note_t e;
   int n_fail = 0;
   int samples_checked = 0;
   logic [7:0] w_m = 8'h00;
   logic c_m = 1'b0, dc_m = 1'b0;
   logic [14:0] pc_m = 15'h0000;
   logic [6:0] lat_m = 7'h00;
   logic [15:0] ptr_m = 16'h0000;
   op_t sops[4] = '{arith_shift_right_op, logic_shift_right_op, logic_shift_left_op,
                    arith_shift_left_alias};
   always #12.5 clock = ~clock;
   alu_core i_alu_core (.clock(clock), .rst_n(rst_n), .issue(issue), .op(op),
      .file_in(file_in), .literal(literal), .wreg_load(wreg_load), .wreg_in(wreg_in),
      .latch_load(latch_load), .latch_in(latch_in), .ptr_lo_load(ptr_lo_load),
      .ptr_hi_load(ptr_hi_load), .ptr_byte_in(ptr_byte_in), .prog_word(prog_word),
      .ram_data(ram_data), .stack_top(stack_top), .busy(busy), .done(done),
      .result(result), .wreg(wreg), .carry(carry), .digit_carry(digit_carry),
      .zero(zero), .pc(pc), .pointer0_low_byte(pointer0_low_byte),
      .pointer0_high_byte(pointer0_high_byte), .prog_addr(prog_addr),
      .ram_addr(ram_addr), .push(push), .pop(pop), .push_addr(push_addr));
   task automatic bad(input logic [15:0] g, input logic [15:0] x);
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
   endtask
   task automatic cmp_data(input logic [7:0] g, input logic [7:0] x);
      samples_checked++;
      if (g !== x) bad({8'h00, g}, {8'h00, x});
   endtask
   task automatic cmp_flag(input logic g, input logic x);
      samples_checked++;
      if (g !== x) bad({15'h0000, g}, {15'h0000, x});
   endtask
   task automatic cmp_addr(input logic [15:0] g, input logic [15:0] x);
      samples_checked++;
      if (g !== x) bad(g, x);
   endtask
   task automatic close_out();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Side loads: 0 working register, 1 pc latch, 2 pointer low, 3 pointer high.
   task automatic set_reg(input int k, input logic [7:0] v);
      @(posedge clock);
      wreg_load <= (k == 0);
      latch_load <= (k == 1);
      ptr_lo_load <= (k == 2);
      ptr_hi_load <= (k == 3);
      wreg_in <= v;
      latch_in <= v[6:0];
      ptr_byte_in <= v;
      if (k == 0) w_m = v;
      if (k == 1) lat_m = v[6:0];
      if (k == 2) ptr_m[7:0] = v;
      if (k == 3) ptr_m[15:8] = v;
      @(posedge clock);
      {wreg_load, latch_load, ptr_lo_load, ptr_hi_load} <= 4'h0;
   endtask
   // Spam keeps issue high into the busy cycle; a second take would bump pc twice.
   task automatic run(input op_t o, input logic [7:0] f, input int cyc, input bit spam,
                      input note_t n);
      int k;
      k = 0;
      q.push_back(n);
      @(posedge clock);
      issue <= 1'b1;
      op <= o;
      file_in <= f;
      @(posedge clock);
      if (spam) begin
         @(posedge clock);
         k = 1;
         cmp_flag(busy, 1'b1);
      end
      issue <= 1'b0;
      do begin
         @(posedge clock);
         k++;
         if (k == 1) cmp_flag(busy, cyc > 1);
      end while (done !== 1'b1 && k < 10);
      // A hang counts as a mismatch; the run still ends at the closing report.
      if (done !== 1'b1) begin
         n_fail++;
      end
      cmp_addr(16'(k), 16'(cyc));
   endtask
   task automatic arith_op(input op_t o, input logic [7:0] f);
      note_t n;
      logic [8:0] s;
      logic [4:0] h;
      n = '{default: 0};
      h = 5'h00;
      case (o)
         add_with_carry_op: begin
            s = {1'b0, f} + {1'b0, w_m} + {8'h00, c_m};
            h = {1'b0, f[3:0]} + {1'b0, w_m[3:0]} + {4'h0, c_m};
         end
         subtract_with_borrow_op: begin
            s = {1'b0, f} - {1'b0, w_m} - {8'h00, ~c_m};
            h = {1'b0, f[3:0]} - {1'b0, w_m[3:0]} - {4'h0, ~c_m};
            s[8] = ~s[8];
            h[4] = ~h[4];
         end
         arith_shift_right_op: s = {f[0], f[7], f[7:1]};
         logic_shift_right_op: s = {f[0], 1'b0, f[7:1]};
         default: s = {f[7], f[6:0], 1'b0};
      endcase
      n.res = s[7:0];
      n.c = s[8];
      n.dc = (o == add_with_carry_op || o == subtract_with_borrow_op) ? h[4] : dc_m;
      n.z = (s[7:0] == 8'h00);
      c_m = n.c;
      dc_m = n.dc;
      pc_m = pc_m + 15'h0001;
      n.pc = pc_m;
      run(o, f, 1, 1'b0, n);
   endtask
   task automatic flow(input op_t o, input bit spam, input logic [7:0] w_new,
                       input logic [14:0] pc_new, input logic pu, input logic po);
      note_t n;
      n = '{default: 0};
      n.kind = 1;
      n.w = w_new;
      n.pc = pc_new;
      n.pu = pu;
      n.po = po;
      n.paddr = pc_m + 15'h0001;
      w_m = w_new;
      pc_m = pc_new;
      run(o, 8'h00, (o == indirect_load_op && !ptr_m[15]) ? 1 : 2, spam, n);
   endtask
   always @(posedge clock) begin
      if (rst_n === 1'b1 && done === 1'b1) begin
         if (q.size() == 0) begin
            bad(16'h0001, 16'h0000);
         end else begin
            e = q.pop_front();
            cmp_addr({1'b0, pc}, {1'b0, e.pc});
            cmp_flag(busy, 1'b0);
            if (e.kind == 0) begin
               cmp_data(result, e.res);
               cmp_flag(carry, e.c);
               cmp_flag(digit_carry, e.dc);
               cmp_flag(zero, e.z);
            end else begin
               cmp_data(wreg, e.w);
               cmp_flag(push, e.pu);
               cmp_flag(pop, e.po);
               if (e.pu === 1'b1) cmp_addr({1'b0, push_addr}, {1'b0, e.paddr});
            end
         end
      end
   end
   initial begin
      void'($urandom(19521));
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      cmp_addr({1'b0, pc}, {1'b0, pc_rst});
      cmp_data(wreg, wreg_rst);
      foreach (sops[i]) begin
         arith_op(sops[i], 8'h7f);
         arith_op(sops[i], 8'h80);
      end
      repeat (8) arith_op(sops[$urandom_range(3)], 8'($urandom));
      repeat (16) begin
         set_reg(0, 8'($urandom));
         arith_op($urandom_range(1) ? add_with_carry_op : subtract_with_borrow_op,
                  8'($urandom));
      end
      for (int p = 0; p < 2; p++) begin
         set_reg(3, (p == 1) ? (8'h80 | 8'($urandom)) : (8'h7f & 8'($urandom)));
         set_reg(2, 8'($urandom));
         @(posedge clock);
         cmp_addr({pointer0_high_byte, pointer0_low_byte}, ptr_m);
         cmp_addr(ram_addr, ptr_m);
         cmp_addr({1'b0, prog_addr}, {1'b0, ptr_m[14:0]});
         ram_data <= 8'($urandom);
         prog_word <= 14'($urandom);
         @(posedge clock);
         flow(indirect_load_op, p == 1, (p == 1) ? prog_word[7:0] : ram_data, pc_m + 15'h0001,
              1'b0, 1'b0);
      end
      repeat (3) begin
         set_reg(1, 8'($urandom));
         set_reg(0, 8'($urandom));
         flow(call_by_accumulator_op, 1'b0, w_m, {lat_m, w_m}, 1'b1, 1'b0);
         @(posedge clock);
         literal <= 8'($urandom);
         stack_top <= 15'($urandom);
         @(posedge clock);
         flow(return_with_literal_op, 1'b0, literal, stack_top, 1'b0, 1'b1);
         set_reg(0, 8'($urandom));
         flow(branch_by_accumulator_op, 1'b0, w_m, pc_m + 15'h0001 + {7'h00, w_m}, 1'b0,
              1'b0);
      end
      set_reg(0, 8'hff);
      flow(branch_by_accumulator_op, 1'b0, w_m, pc_m + 15'h0100, 1'b0, 1'b0);
      repeat (2) @(posedge clock);
      cmp_addr(16'(q.size()), 16'h0000);
      close_out();
   end
endmodule
`default_nettype wire
